// ---- shared/scan_test_pkg.sv ----
// constants and types for the boundary-scan test access logic
package scan_test_pkg;
  localparam int instr_width = 3;
  localparam logic [2:0] instr_external_test = 3'h0;
  localparam logic [2:0] instr_sample_preload = 3'h1;
  localparam logic [2:0] instr_float_pads = 3'h5;
  localparam logic [2:0] instr_continuity = 3'h6;
  localparam logic [2:0] instr_bypass = 3'h7;
  localparam logic [2:0] instr_reset_value = 3'h7;
  localparam logic [2:0] instr_capture_value = 3'h1;
  localparam int pad_count = 42;
  localparam int internal_count = 11;
  localparam int chain_length = pad_count + internal_count;

  typedef enum logic [3:0] {
    st_test_reset = 4'h0,
    st_run_idle = 4'h1,
    st_select_dr = 4'h2,
    st_capture_dr = 4'h3,
    st_shift_dr = 4'h4,
    st_exit1_dr = 4'h5,
    st_pause_dr = 4'h6,
    st_exit2_dr = 4'h7,
    st_update_dr = 4'h8,
    st_select_ir = 4'h9,
    st_capture_ir = 4'ha,
    st_shift_ir = 4'hb,
    st_exit1_ir = 4'hc,
    st_pause_ir = 4'hd,
    st_exit2_ir = 4'he,
    st_update_ir = 4'hf
  } tap_state_type;
endpackage

// ---- verilog/scan_test_access.sv ----
// boundary-scan test access port with instruction, bypass and boundary registers
//
// Operation
// - four-wire serial test port: test clock, data in, data out, mode select
// - exactly three scan registers: instruction, bypass, boundary
// - instruction register is 3-bit shift register, latched on update and decoded as current instruction
// - instruction selects shifted data register and controls test feature
// - code 000 shifts boundary register and drives its contents onto pins
// - code 001 captures live pins, shifts out, allows preload
// - code 101 floats pci and serial rom pads; other ports normal
// - code 110 enters production continuity test mode
// - code 111 puts only bypass register between data in and out
// - bypass selected: test logic never affects normal operation
// - at power-up reset logic and load bypass instruction automatically
// - bypass register is one stage, default data path
// - full sixteen-state access state machine makes capture, shift, update
// - boundary cells cover pci and serial rom pads and enable controls
// - in external test a pad drives only when its enable cell holds one
// - eleven internal non-pad cells placed after the pad cells at the chain end
`timescale 1ns/1ps
module scan_test_access
  import scan_test_pkg::*;
#(
  parameter int npads = scan_test_pkg::pad_count,
  parameter int ninternal = scan_test_pkg::internal_count
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic test_clock,
  input wire logic test_data_in,
  input wire logic test_mode_select,
  output logic test_data_out,
  output logic test_data_out_oe,
  input wire logic [npads-1:0] pad_in,
  input wire logic [npads-1:0] core_out,
  input wire logic [npads-1:0] core_oe,
  output logic [npads-1:0] pad_out,
  output logic [npads-1:0] pad_oe,
  output logic continuity_mode
);
  import scan_test_pkg::*;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync1_reg, sync1_next;
  logic [2:0] sync2_reg, sync2_next;
  // pads are async pins: capture reads only the second stage
  logic [npads-1:0] pad_sync1_reg, pad_sync1_next;
  logic [npads-1:0] pad_sync2_reg, pad_sync2_next;
  logic tck_last_reg, tck_last_next;
  logic tck_rise, tck_fall;

  always_comb begin
    sync1_next = {test_clock, test_data_in, test_mode_select};
    sync2_next = sync1_reg;
    pad_sync1_next = pad_in;
    pad_sync2_next = pad_sync1_reg;
    tck_last_next = sync2_reg[2];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      pad_sync1_reg <= '0;
      pad_sync2_reg <= '0;
      tck_last_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      pad_sync1_reg <= pad_sync1_next;
      pad_sync2_reg <= pad_sync2_next;
      tck_last_reg <= tck_last_next;
    end
  end

  assign tck_rise = sync2_reg[2] & ~tck_last_reg;
  assign tck_fall = ~sync2_reg[2] & tck_last_reg;

  // ------------------------------------------------------------
  // access state machine
  // ------------------------------------------------------------
  tap_state_type state_reg, state_next;
  logic tms;
  logic tdi;
  assign tms = sync2_reg[0];
  assign tdi = sync2_reg[1];

  always_comb begin
    state_next = state_reg;
    if (tck_rise) begin
      unique case (state_reg)
        st_test_reset: state_next = tms ? st_test_reset : st_run_idle;
        st_run_idle: state_next = tms ? st_select_dr : st_run_idle;
        st_select_dr: state_next = tms ? st_select_ir : st_capture_dr;
        st_capture_dr: state_next = tms ? st_exit1_dr : st_shift_dr;
        st_shift_dr: state_next = tms ? st_exit1_dr : st_shift_dr;
        st_exit1_dr: state_next = tms ? st_update_dr : st_pause_dr;
        st_pause_dr: state_next = tms ? st_exit2_dr : st_pause_dr;
        st_exit2_dr: state_next = tms ? st_update_dr : st_shift_dr;
        st_update_dr: state_next = tms ? st_select_dr : st_run_idle;
        st_select_ir: state_next = tms ? st_test_reset : st_capture_ir;
        st_capture_ir: state_next = tms ? st_exit1_ir : st_shift_ir;
        st_shift_ir: state_next = tms ? st_exit1_ir : st_shift_ir;
        st_exit1_ir: state_next = tms ? st_update_ir : st_pause_ir;
        st_pause_ir: state_next = tms ? st_exit2_ir : st_pause_ir;
        st_exit2_ir: state_next = tms ? st_update_ir : st_shift_ir;
        st_update_ir: state_next = tms ? st_select_dr : st_run_idle;
      endcase
    end
  end

  // reset lands in test-logic-reset, which also reloads the bypass instruction
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= st_test_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------
  logic [instr_width-1:0] ir_shift_reg, ir_shift_next;
  logic [instr_width-1:0] instruction_bits_reg, instruction_bits_next;

  always_comb begin
    ir_shift_next = ir_shift_reg;
    instruction_bits_next = instruction_bits_reg;
    if (state_reg == st_test_reset) begin
      instruction_bits_next = instr_reset_value;
    end
    if (tck_rise) begin
      unique case (state_reg)
        st_capture_ir: ir_shift_next = instr_capture_value;
        st_shift_ir: ir_shift_next = {tdi, ir_shift_reg[instr_width-1:1]};
        default: ir_shift_next = ir_shift_reg;
      endcase
    end
    // falling-edge update swaps in the new instruction halfway through the update state
    if (tck_fall && state_reg == st_update_ir) begin
      instruction_bits_next = ir_shift_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ir_shift_reg <= instr_capture_value;
      instruction_bits_reg <= instr_reset_value;
    end else begin
      ir_shift_reg <= ir_shift_next;
      instruction_bits_reg <= instruction_bits_next;
    end
  end

  // instruction decoding; unlisted codes fall to bypass
  // reserved codes must never touch the pads, so they act as bypass
  function automatic logic [2:0] decode_instr(input logic [2:0] code);
    logic [2:0] mode;
    mode = instr_bypass;
    unique case (code)
      instr_external_test: mode = instr_external_test;
      instr_sample_preload: mode = instr_sample_preload;
      instr_float_pads: mode = instr_float_pads;
      instr_continuity: mode = instr_continuity;
      default: mode = instr_bypass;
    endcase
    return mode;
  endfunction

  logic [2:0] mode;
  logic sel_boundary;
  assign mode = decode_instr(instruction_bits_reg);
  assign sel_boundary = (mode == instr_external_test) || (mode == instr_sample_preload);

  // ------------------------------------------------------------
  // bypass and boundary registers
  // ------------------------------------------------------------
  localparam int nchain = npads + ninternal;
  logic bypass_reg, bypass_next;
  logic [nchain-1:0] bscan_shift_reg, bscan_shift_next;
  logic [nchain-1:0] bscan_hold_reg, bscan_hold_next;
  logic [nchain-1:0] capture_vec;

  // internal cells placed after the pad cells at chain end
  genvar gi;
  generate
    for (gi = 0; gi < nchain; gi++) begin : g_cap
      if (gi < npads) begin : g_pad
        assign capture_vec[gi] = pad_sync2_reg[gi];
      end else begin : g_int
        assign capture_vec[gi] = bscan_hold_reg[gi];
      end
    end
  endgenerate

  always_comb begin
    bypass_next = bypass_reg;
    bscan_shift_next = bscan_shift_reg;
    bscan_hold_next = bscan_hold_reg;
    if (tck_rise) begin
      if (state_reg == st_capture_dr) begin
        bypass_next = 1'b0;
        if (sel_boundary) begin
          bscan_shift_next = capture_vec;
        end
      end else if (state_reg == st_shift_dr) begin
        if (sel_boundary) begin
          bscan_shift_next = {tdi, bscan_shift_reg[nchain-1:1]};
        end else begin
          bypass_next = tdi;
        end
      end
    end
    // hold cells change on the fall so pads never see a half-shifted chain
    if (tck_fall && state_reg == st_update_dr && sel_boundary) begin
      bscan_hold_next = bscan_shift_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bypass_reg <= 1'b0;
      bscan_shift_reg <= '0;
      bscan_hold_reg <= '0;
    end else begin
      bypass_reg <= bypass_next;
      bscan_shift_reg <= bscan_shift_next;
      bscan_hold_reg <= bscan_hold_next;
    end
  end

  // ------------------------------------------------------------
  // serial output and pad control
  // ------------------------------------------------------------
  logic tdo_reg, tdo_next;
  logic tdo_oe_reg, tdo_oe_next;
  logic [npads-1:0] pad_out_reg, pad_out_next;
  logic [npads-1:0] pad_oe_reg, pad_oe_next;
  logic cont_reg, cont_next;
  logic [npads-1:0] cell_en;

  // each pad's enable follows the hold cell at the next odd index (even pads share the following cell)
  generate
    for (gi = 0; gi < npads; gi++) begin : g_en
      assign cell_en[gi] = bscan_hold_reg[gi | 1];
    end
  endgenerate

  // data out moves half a test clock after the far side samples on the rise
  always_comb begin
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tck_fall) begin
      tdo_oe_next = (state_reg == st_shift_dr) || (state_reg == st_shift_ir);
      if (state_reg == st_shift_ir) begin
        tdo_next = ir_shift_reg[0];
      end else if (sel_boundary) begin
        tdo_next = bscan_shift_reg[0];
      end else begin
        tdo_next = bypass_reg;
      end
    end
    pad_out_next = core_out;
    pad_oe_next = core_oe;
    cont_next = (mode == instr_continuity);
    if (mode == instr_external_test) begin
      pad_out_next = bscan_hold_reg[npads-1:0];
      pad_oe_next = cell_en;
    end else if (mode == instr_float_pads) begin
      pad_oe_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
      pad_out_reg <= '0;
      pad_oe_reg <= '0;
      cont_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
      pad_out_reg <= pad_out_next;
      pad_oe_reg <= pad_oe_next;
      cont_reg <= cont_next;
    end
  end

  assign test_data_out = tdo_reg;
  assign test_data_out_oe = tdo_oe_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign continuity_mode = cont_reg;
endmodule // scan_test_access

// ---- test/scan_test_access_asserts.sv ----
// assertions on the scan test access ports
`timescale 1ns/1ps
module scan_test_access_asserts #(
  parameter int npads = 42
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic test_clock,
  input wire logic test_data_out,
  input wire logic test_data_out_oe,
  input wire logic [npads-1:0] core_out,
  input wire logic [npads-1:0] core_oe,
  input wire logic [npads-1:0] pad_out,
  input wire logic [npads-1:0] pad_oe,
  input wire logic continuity_mode
);
  // ----
  // cycles since the last test clock fall and edge
  // ----
  logic tck_reg, tck_next;
  logic [3:0] fall_reg, fall_next, edge_reg, edge_next;
  always_comb begin
    tck_next = test_clock;
    fall_next = (fall_reg == 4'hf) ? fall_reg : fall_reg + 4'h1;
    edge_next = (edge_reg == 4'hf) ? edge_reg : edge_reg + 4'h1;
    if (tck_reg && !test_clock) fall_next = 4'h0;
    if (tck_reg != test_clock) edge_next = 4'h0;
  end
  always_ff @(posedge clk) begin
    tck_reg <= tck_next;
    fall_reg <= rstn ? fall_next : 4'hf;
    edge_reg <= rstn ? edge_next : 4'hf;
  end
  default clocking cb @(posedge clk); endclocking
  a_reset_quiet: assert property (disable iff (!rstn)
    $rose(rstn) |-> !test_data_out_oe && !test_data_out) else $error("serial out active");
  a_reset_pads: assert property (disable iff (!rstn) $rose(rstn) |-> pad_out == '0
    && pad_oe == '0 ##1 pad_out == $past(core_out) && pad_oe == $past(core_oe))
    else $error("pads wrong after reset");
  a_reset_cont: assert property (disable iff (!rstn)
    $rose(rstn) |-> !continuity_mode [*2]) else $error("continuity after reset");
  a_tdo_timing: assert property (disable iff (!rstn)
    $changed(test_data_out) |-> fall_reg inside {[4'h1:4'h6]}) else $error("tdo timing");
  a_oe_timing: assert property (disable iff (!rstn)
    $changed(test_data_out_oe) |-> fall_reg inside {[4'h1:4'h6]}) else $error("oe timing");
  a_pad_cause: assert property (disable iff (!rstn) $changed(pad_out)
    |-> pad_out == $past(core_out) || fall_reg inside {[4'h1:4'h7]}) else $error("pad out");
  a_pad_oe_cause: assert property (disable iff (!rstn) $changed(pad_oe)
    |-> pad_oe == $past(core_oe) || fall_reg inside {[4'h1:4'h7]}) else $error("pad oe");
  a_cont_timing: assert property (disable iff (!rstn)
    $changed(continuity_mode) |-> edge_reg inside {[4'h1:4'h7]}) else $error("continuity");
  c_cont: cover property (disable iff (!rstn) $rose(continuity_mode));
  c_shift: cover property (disable iff (!rstn) $rose(test_data_out_oe));
  c_extest: cover property (disable iff (!rstn) pad_oe != core_oe);
endmodule // scan_test_access_asserts
bind scan_test_access scan_test_access_asserts #(.npads(npads)) u_asserts (
  .clk(clk), .rstn(rstn), .test_clock(test_clock), .test_data_out(test_data_out),
  .test_data_out_oe(test_data_out_oe), .core_out(core_out), .core_oe(core_oe),
  .pad_out(pad_out), .pad_oe(pad_oe), .continuity_mode(continuity_mode));

// ---- test/scan_test_host.sv ----
// board scan controller model driving the serial test port
`timescale 1ns/1ps
module scan_test_host (
  input wire logic clk,
  output logic test_clock,
  output logic test_mode_select,
  output logic test_data_in,
  input wire logic test_data_out
);
  // ----
  // one test clock period of 8 clk, clock stands low between steps
  // ----
  initial begin
    test_clock = 1'b0;
    test_mode_select = 1'b1;
    test_data_in = 1'b0;
  end
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk);
    test_mode_select <= tms;
    test_data_in <= tdi;
    repeat (4) @(posedge clk);
    tdo = test_data_out;
    test_clock <= 1'b1;
    repeat (3) @(posedge clk);
    test_clock <= 1'b0;
  endtask
endmodule // scan_test_host

// ---- test/scan_test_access_tb.sv ----
// self-checking bench for the scan test access logic
`timescale 1ns/1ps
module scan_test_access_tb;
  import scan_test_pkg::*;
  // ----
  // signals, rows and tasks
  // ----
  typedef struct {logic [2:0] code; logic cont; logic fl; logic byp;} row_type;
  row_type rows [6] = '{'{3'h2, 1'b0, 1'b0, 1'b1}, '{3'h3, 1'b0, 1'b0, 1'b1},
    '{3'h4, 1'b0, 1'b0, 1'b1}, '{3'h5, 1'b0, 1'b1, 1'b0}, '{3'h6, 1'b1, 1'b0, 1'b0},
    '{3'h7, 1'b0, 1'b0, 1'b1}};
  logic clk, rstn, test_clock, test_data_in, test_mode_select, test_data_out, oe, cont;
  logic [pad_count-1:0] pad_in, core_out, core_oe, pad_out, pad_oe;
  logic [chain_length-1:0] dout;
  logic [2:0] irout;
  logic tdo_line;
  assign tdo_line = oe ? test_data_out : 1'b1;
  int failures, compares;
  scan_test_access DUT (.clk(clk), .rstn(rstn), .test_clock(test_clock),
    .test_data_in(test_data_in), .test_mode_select(test_mode_select),
    .test_data_out(test_data_out), .test_data_out_oe(oe), .pad_in(pad_in),
    .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
    .continuity_mode(cont));
  scan_test_host host (.clk(clk), .test_clock(test_clock), .test_mode_select(test_mode_select),
    .test_data_in(test_data_in), .test_data_out(tdo_line));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic walk(input logic [7:0] tms, input int n);
    logic b;
    for (int i = 0; i < n; i++) host.step(tms[i], 1'b0, b);
  endtask
  task automatic ir_load(input logic [2:0] code);
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) host.step(i == 2, code[i], irout[i]);
    walk(8'h01, 2);
  endtask
  task automatic dr_scan(input logic [chain_length-1:0] din);
    walk(8'h01, 3);
    for (int i = 0; i < chain_length; i++) begin
      host.step(i == chain_length - 1, din[i], dout[i]);
      if (i == 0) check(oe, 1'b1);
    end
    walk(8'h01, 2);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    failures = 0;
    compares = 0;
    rstn = 1'b0;
    pad_in = '0;
    core_out = '0;
    core_oe = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    core_out <= 42'h2aa_5555_aaaa;
    core_oe <= 42'h0ff_0f0f_f0f0;
    pad_in <= 42'h123_4567_89ab;
    repeat (3) @(posedge clk);
    check(pad_out, core_out);
    check(pad_oe, core_oe);
    walk(8'h00, 1);
    dr_scan(53'h1);
    check(dout, 53'h2);
    check(oe, 1'b0);
    $display("reset test done");
    foreach (rows[r]) begin
      ir_load(rows[r].code);
      check(irout[1:0], 2'b01);
      check(cont, rows[r].cont);
      check(pad_oe, {pad_count{~rows[r].fl}} & core_oe);
      if (rows[r].byp) begin
        dr_scan(53'h1);
        check(dout, 53'h2);
      end
      $display("row %0d done", r);
    end
    ir_load(instr_sample_preload);
    dr_scan(53'h0);
    check(dout[pad_count-1:0], pad_in);
    check(pad_out, core_out);
    ir_load(instr_external_test);
    check(pad_oe, 42'h0);
    dr_scan({chain_length{1'b1}});
    check({pad_out, pad_oe}, {84{1'b1}});
    dr_scan(53'h0_5555_5555_5555);
    check({pad_out, pad_oe}, {42'h155_5555_5555, 42'h0});
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    check(pad_out, core_out);
    $display("external test done");
    walk(8'h00, 1);
    ir_load(instr_continuity);
    walk(8'h1f, 5);
    walk(8'h00, 1);
    check(cont, 1'b0);
    dr_scan(53'h1);
    check(dout, 53'h2);
    $display("state reset test done");
    test_done();
  end
endmodule // scan_test_access_tb
